/* File: common/imas_pkg.sv */
package imas_pkg;
  // System clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PS = 25000;
  // Bus timing figures in nanoseconds, as printed
  localparam int unsigned HD_STA_STD_NS = 4000;
  localparam int unsigned HD_STA_FST_NS = 600;
  localparam int unsigned SU_STA_STD_NS = 4700;
  localparam int unsigned SU_STA_FST_NS = 600;
  localparam int unsigned BUF_STD_NS    = 4700;
  localparam int unsigned BUF_FST_NS    = 1300;
  localparam int unsigned LOW_STD_NS    = 4700;
  localparam int unsigned LOW_FST_NS    = 1300;
  localparam int unsigned HIGH_STD_NS   = 4000;
  localparam int unsigned HIGH_FST_NS   = 600;
  localparam int unsigned HD_DAT_NS     = 300;
  localparam int unsigned SU_DAT_NS     = 250;
  // Least times round up to whole cycles
  localparam int unsigned HD_STA_STD =
    (HD_STA_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HD_STA_FST =
    (HD_STA_FST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SU_STA_STD =
    (SU_STA_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SU_STA_FST =
    (SU_STA_FST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BUF_STD =
    (BUF_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BUF_FST =
    (BUF_FST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned LOW_STD =
    (LOW_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned LOW_FST =
    (LOW_FST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HIGH_STD =
    (HIGH_STD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HIGH_FST =
    (HIGH_FST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HD_DAT =
    (HD_DAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SU_DAT =
    (SU_DAT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Width of all timing counters
  localparam int unsigned CNT_W = 10;
  // Bits in a byte, not counting the ack slot
  localparam int unsigned BYTE_BITS = 8;
endpackage : imas_pkg

/* File: common/imas_bus_if.sv */
`timescale 1ns/1ps
// Shared open-drain wires between the two ends
interface imas_bus_if;
  logic sclDevOe;  // Device pulls SCL low
  logic sdaDevOe;  // Device pulls SDA low
  logic sclOthOe;  // Other party pulls SCL low
  logic sdaOthOe;  // Other party pulls SDA low
  logic scl;       // Wired-AND level
  logic sda;       // Wired-AND level
  // Pull-ups win unless someone drives low
  assign scl = ~(sclDevOe | sclOthOe);
  assign sda = ~(sdaDevOe | sdaOthOe);
  modport device (input scl, input sda, output sclDevOe, output sdaDevOe);
  modport other  (input scl, input sda, output sclOthOe, output sdaOthOe);
endinterface : imas_bus_if

/* File: verilog/imas_sync_edge.sv */
`timescale 1ns/1ps
// Two-flop synchroniser pair with edge detect on the stable copy
module imas_sync_edge (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclQ,
  output logic      sdaQ,
  output logic      sclRise,
  output logic      sclFall,
  output logic      sdaRise,
  output logic      sdaFall
);
  logic [1:0] meta_reg;  // First stage, read only by stage two
  logic [1:0] sync_reg;  // Stable copy
  logic [1:0] prev_reg;  // Previous stable copy

  // Idle bus reads high, so reset to ones
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      prev_reg <= 2'h3;
    end
    else
    begin
      meta_reg <= {scl, sda};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign sclQ    = sync_reg[1];
  assign sdaQ    = sync_reg[0];
  assign sclRise = sync_reg[1] & ~prev_reg[1];
  assign sclFall = ~sync_reg[1] & prev_reg[1];
  assign sdaRise = sync_reg[0] & ~prev_reg[0];
  assign sdaFall = ~sync_reg[0] & prev_reg[0];
endmodule : imas_sync_edge

/* File: verilog/imas_master.sv */
`timescale 1ns/1ps
// Overview of operation
// - Compare data line only while clock high
// - Lost when releasing high but reading low
// - After loss, clock only to byte end
// - Arbitration checks continue through data bytes
// - On loss, switch to slave receiver
// - Illegal arbitration cases are avoided by system
// - Low count starts at any clock fall
// - Hold clock low until low count expires
// - Wait high without counting while line low
// - Count high from rise; first done pulls
// - Hold time after start before first fall
// - Setup time before repeated start
// - Bus free time after stop
// - Hold data 300 ns after clock fall
// - Data set up 250 ns before release
// - Start/stop only while clock high
// - Repeated start keeps the bus
module imas_master #(
  parameter int unsigned LOW_CNT  = imas_pkg::LOW_STD,
  parameter int unsigned HIGH_CNT = imas_pkg::HIGH_STD
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  imas_bus_if.device      bus,
  input  wire logic       fastMode,
  input  wire logic       cmdStart,
  input  wire logic       cmdStop,
  input  wire logic       cmdByte,
  input  wire logic [7:0] txByte,
  input  wire logic       clrArbLost,
  output logic            busy,
  output logic            byteDone,
  output logic [7:0]      rxByte,
  output logic            arbLost,
  output logic            slaveMode
);
  localparam int unsigned CNT_W = imas_pkg::CNT_W;  // Counter width
  // Elaboration check on counts
  if (LOW_CNT < 2 || LOW_CNT >= (1 << imas_pkg::CNT_W) ||
      HIGH_CNT < 2 || HIGH_CNT >= (1 << imas_pkg::CNT_W))
    $error("imas_master: period counts out of range");

  typedef enum logic [2:0] {
    IMAS_IDLE, IMAS_START, IMAS_LOW, IMAS_HWAIT, IMAS_HIGH,
    IMAS_STOP, IMAS_RSU
  } imas_state_t;

  imas_state_t state_reg;           // Master sequencer
  logic [CNT_W-1:0] cnt_reg;        // Shared period counter
  logic [CNT_W-1:0] busFree_reg;    // Idle time since stop
  logic [3:0]  bitIdx_reg;          // Bit in byte, 8 = ack
  logic [8:0]  shift_reg;           // Byte plus ack release
  logic        sclOe_reg;           // SCL pull
  logic        sdaOe_reg;           // SDA pull
  logic        lostByte_reg;        // Lost in this byte
  logic        sclQ, sdaQ, sclRise, sclFall, sdaRise, sdaFall;

  // Synchronised bus view
  imas_sync_edge u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .scl     (bus.scl),
    .sda     (bus.sda),
    .sclQ    (sclQ),
    .sdaQ    (sdaQ),
    .sclRise (sclRise),
    .sclFall (sclFall),
    .sdaRise (sdaRise),
    .sdaFall (sdaFall)
  );

  // Mode-dependent counts; low/high from parameters in standard mode, from the package in fast mode
  function automatic logic [CNT_W-1:0] pick(input logic f,
                                            input int unsigned s,
                                            input int unsigned q);
    pick = f ? CNT_W'(q) : CNT_W'(s);
  endfunction : pick

  logic [CNT_W-1:0] lowCnt, highCnt;
  assign lowCnt  = fastMode ? CNT_W'(imas_pkg::LOW_FST) : CNT_W'(LOW_CNT);
  assign highCnt = fastMode ? CNT_W'(imas_pkg::HIGH_FST)
                            : CNT_W'(HIGH_CNT);

  // Released bit reads low, clock high
  logic arbHit;
  assign arbHit = (state_reg == IMAS_HIGH) && sclQ && !sdaOe_reg &&
                  !sdaQ && bitIdx_reg < 4'h8 && !lostByte_reg;

  // Bus free counter; restarts on any activity
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      busFree_reg <= '0;
    else if (!sclQ || !sdaQ || sdaFall)
      busFree_reg <= '0;
    else if (busFree_reg != '1)
      busFree_reg <= busFree_reg + 1'b1;
  end

  // Main sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= IMAS_IDLE;
      cnt_reg      <= '0;
      bitIdx_reg   <= '0;
      shift_reg    <= '1;
      sclOe_reg    <= 1'b0;
      sdaOe_reg    <= 1'b0;
      lostByte_reg <= 1'b0;
      byteDone     <= 1'b0;
      rxByte       <= '0;
    end
    else
    begin
      byteDone <= 1'b0;
      case (state_reg)
        IMAS_IDLE:
          // Start only on a free bus
          if (cmdStart && sclQ && sdaQ && !slaveMode &&
              busFree_reg >= pick(fastMode, imas_pkg::BUF_STD,
                                  imas_pkg::BUF_FST))
          begin
            sdaOe_reg <= 1'b1;  // Data falls, clock high
            cnt_reg   <= '0;
            state_reg <= IMAS_START;
          end
        IMAS_START:
          // Hold before first fall; a foreign fall ends it
          if (sclFall || cnt_reg >= pick(fastMode, imas_pkg::HD_STA_STD,
                                         imas_pkg::HD_STA_FST))
          begin
            sclOe_reg  <= 1'b1;
            cnt_reg    <= sclFall ? CNT_W'(1) : '0;
            bitIdx_reg <= '0;
            state_reg  <= IMAS_LOW;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        IMAS_LOW:
        begin
          // Low period; hold line down until count ends
          cnt_reg <= cnt_reg + 1'b1;
          // Change data after hold delay only
          if (cnt_reg == CNT_W'(imas_pkg::HD_DAT))
            sdaOe_reg <= lostByte_reg ? 1'b0
                         : ~shift_reg[8];
          if (cnt_reg >= lowCnt)
          begin
            sclOe_reg <= 1'b0;
            state_reg <= IMAS_HWAIT;
          end
        end
        IMAS_HWAIT:
          // Wait until line really high
          if (sclQ)
          begin
            cnt_reg   <= '0;
            state_reg <= IMAS_HIGH;
          end
        IMAS_HIGH:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (arbHit)
          begin
            lostByte_reg <= 1'b1;
            sdaOe_reg    <= 1'b0;  // Release data at once
          end
          if (sclFall || cnt_reg >= highCnt)
          begin
            // Someone else or our count ends the high
            rxByte     <= {rxByte[6:0], sdaQ};
            shift_reg  <= {shift_reg[7:0], 1'b1};
            sclOe_reg  <= 1'b1;
            cnt_reg    <= sclFall ? CNT_W'(1) : '0;
            if (bitIdx_reg == 4'h8)
            begin
              byteDone   <= 1'b1;
              bitIdx_reg <= '0;
              if (lostByte_reg)
              begin
                // Stop clocking at byte end
                sclOe_reg    <= 1'b0;
                lostByte_reg <= 1'b0;
                state_reg    <= IMAS_IDLE;
              end
              else if (cmdStart || cmdStop)
                state_reg <= IMAS_STOP;
              else
                state_reg <= IMAS_LOW;
            end
            else
            begin
              bitIdx_reg <= bitIdx_reg + 1'b1;
              state_reg  <= IMAS_LOW;
            end
          end
          // Load next byte during the ack slot
          if (bitIdx_reg == 4'h8 && cmdByte)
            shift_reg <= {txByte, 1'b1};
        end
        IMAS_STOP:
        begin
          // Clock low: set data for stop (low) or rstart (high)
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(imas_pkg::HD_DAT))
            sdaOe_reg <= cmdStop;
          if (cnt_reg >= lowCnt)
          begin
            sclOe_reg <= 1'b0;
            cnt_reg   <= '0;
            state_reg <= IMAS_RSU;
          end
        end
        IMAS_RSU:
          // Clock high; setup before edge on data
          if (!sclQ)
            cnt_reg <= '0;
          else if (cnt_reg >= pick(fastMode, imas_pkg::SU_STA_STD,
                                   imas_pkg::SU_STA_FST))
          begin
            sdaOe_reg <= ~sdaOe_reg;  // Low=rstart, high=stop
            cnt_reg   <= '0;
            state_reg <= sdaOe_reg ? IMAS_IDLE : IMAS_START;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        default:
          state_reg <= IMAS_IDLE;
      endcase
    end
  end

  // Sticky flag; a loss beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      arbLost <= 1'b0;
    else if (arbHit)
      arbLost <= 1'b1;
    else if (clrArbLost)
      arbLost <= 1'b0;
  end

  // Drop into slave receiver on loss, leave at stop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      slaveMode <= 1'b0;
    else if (arbHit)
      slaveMode <= 1'b1;
    else if (sclQ && sdaRise)
      slaveMode <= 1'b0;
  end

  // Busy output register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      busy <= 1'b0;
    else
      busy <= (state_reg != IMAS_IDLE);
  end

  assign bus.sclDevOe = sclOe_reg;
  assign bus.sdaDevOe = sdaOe_reg;
endmodule : imas_master

/* File: verilog/imas_other.sv */
`timescale 1ns/1ps
// Competing master: clocks bytes with its own periods, wired-AND aware
module imas_other #(
  parameter int unsigned LOW_CNT  = imas_pkg::LOW_FST,
  parameter int unsigned HIGH_CNT = imas_pkg::HIGH_FST
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  imas_bus_if.other       bus,
  input  wire logic       go,
  input  wire logic [7:0] txByte,
  output logic            lost,
  output logic            done
);
  localparam int unsigned CNT_W = imas_pkg::CNT_W;  // Counter width
  // Elaboration check on counts
  if (LOW_CNT < 2 || LOW_CNT >= (1 << imas_pkg::CNT_W) ||
      HIGH_CNT < 2 || HIGH_CNT >= (1 << imas_pkg::CNT_W))
    $error("imas_other: period counts out of range");

  typedef enum logic [2:0] {
    IMOT_IDLE, IMOT_START, IMOT_LOW, IMOT_HWAIT, IMOT_HIGH
  } imas_ostate_t;

  imas_ostate_t     state_reg;  // Sequencer
  logic [CNT_W-1:0] cnt_reg;    // Period counter
  logic [3:0]       bit_reg;    // Bit index, 8 = ack
  logic [8:0]       sh_reg;     // Byte plus released ack
  logic             sclOe_reg;
  logic             sdaOe_reg;
  logic             sclQ, sdaQ, sclFall;

  imas_sync_edge u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .scl     (bus.scl),
    .sda     (bus.sda),
    .sclQ    (sclQ),
    .sdaQ    (sdaQ),
    .sclRise (),
    .sclFall (sclFall),
    .sdaRise (),
    .sdaFall ()
  );

  // One byte per go; releases both lines after it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= IMOT_IDLE;
      cnt_reg   <= '0;
      bit_reg   <= '0;
      sh_reg    <= '1;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      lost      <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        IMOT_IDLE:
          if (go && sclQ && sdaQ)
          begin
            sdaOe_reg <= 1'b1;
            sh_reg    <= {txByte, 1'b1};
            lost      <= 1'b0;
            cnt_reg   <= '0;
            state_reg <= IMOT_START;
          end
        IMOT_START:
          if (cnt_reg >= CNT_W'(imas_pkg::HD_STA_FST))
          begin
            sclOe_reg <= 1'b1;
            cnt_reg   <= '0;
            bit_reg   <= '0;
            state_reg <= IMOT_LOW;
          end
          else
            cnt_reg <= cnt_reg + 1'b1;
        IMOT_LOW:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(imas_pkg::HD_DAT))
            sdaOe_reg <= !lost && !sh_reg[8];
          if (cnt_reg >= CNT_W'(LOW_CNT))
          begin
            sclOe_reg <= 1'b0;
            state_reg <= IMOT_HWAIT;
          end
        end
        IMOT_HWAIT:
          if (sclQ)
          begin
            cnt_reg   <= '0;
            state_reg <= IMOT_HIGH;
          end
        IMOT_HIGH:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (!sdaOe_reg && !sdaQ && bit_reg < 4'h8)
            lost <= 1'b1;
          if (sclFall || cnt_reg >= CNT_W'(HIGH_CNT))
          begin
            sh_reg  <= {sh_reg[7:0], 1'b1};
            cnt_reg <= sclFall ? CNT_W'(1) : '0;
            if (bit_reg == 4'h8)
            begin
              sclOe_reg <= 1'b0;
              sdaOe_reg <= 1'b0;
              done      <= 1'b1;
              state_reg <= IMOT_IDLE;
            end
            else
            begin
              sclOe_reg <= 1'b1;
              bit_reg   <= bit_reg + 1'b1;
              state_reg <= IMOT_LOW;
            end
          end
        end
        default:
          state_reg <= IMOT_IDLE;
      endcase
    end
  end

  assign bus.sclOthOe = sclOe_reg;
  assign bus.sdaOthOe = sdaOe_reg;
endmodule : imas_other

/* File: bench/imas_bus_props.sv */
`timescale 1ns/1ps
// Wire-level checks on the shared bus and the device status
module imas_bus_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclDevOe,
  input wire logic sdaDevOe,
  input wire logic scl,
  input wire logic sda,
  input wire logic fastMode,
  input wire logic busy,
  input wire logic byteDone,
  input wire logic arbLost,
  input wire logic slaveMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int unsigned holdCnt; // Clock high with data low
  int unsigned freeCnt; // Both lines high
  int unsigned hdMin;   // Start hold for the mode
  int unsigned suMin;   // Restart setup for the mode
  int unsigned bufMin;  // Bus free for the mode
  assign hdMin  = fastMode ? imas_pkg::HD_STA_FST : imas_pkg::HD_STA_STD;
  assign suMin  = fastMode ? imas_pkg::SU_STA_FST : imas_pkg::SU_STA_STD;
  assign bufMin = fastMode ? imas_pkg::BUF_FST : imas_pkg::BUF_STD;
  // Length of the present start-like interval
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !(scl && !sda))
      holdCnt <= 0;
    else
      holdCnt <= holdCnt + 1;
  end
  // Idle length; counts wire level, so never below the device's view while both lines stay high
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !(scl && sda))
      freeCnt <= 0;
    else
      freeCnt <= freeCnt + 1;
  end
  a_lost_release: assert property (
    $rose(arbLost) |-> !sdaDevOe && slaveMode)
    else $error("Data driver kept after loss");
  a_slave_quiet: assert property (
    slaveMode |-> !sdaDevOe)
    else $error("Data driven in slave role");
  a_clock_stop: assert property (
    slaveMode && byteDone |-> ##2 !sclDevOe [*8])
    else $error("Clock kept after lost byte");
  a_low_hold: assert property (
    $rose(sclDevOe) |-> sclDevOe [*8])
    else $error("Clock low released early");
  a_high_count: assert property (
    $rose(scl) |-> !sclDevOe [*8])
    else $error("Clock pulled before high count");
  a_start_hold: assert property (
    $rose(sclDevOe) && $past(scl) && !$past(sda)
      |-> $past(holdCnt) >= hdMin - 1)
    else $error("Start hold too short");
  a_bus_free: assert property (
    $rose(sdaDevOe) && scl && !$past(busy, 2) |-> $past(freeCnt) >= bufMin)
    else $error("Start before bus free time");
  a_rstart_setup: assert property (
    $rose(sdaDevOe) && scl && $past(busy, 2) |-> $past(freeCnt) >= suMin)
    else $error("Repeated start setup too short");
  a_data_hold: assert property (
    $fell(scl) |=> $stable(sdaDevOe) [*8])
    else $error("Data changed right after clock fall");
  a_setup_release: assert property (
    $fell(sclDevOe) |-> sdaDevOe == $past(sdaDevOe, 8))
    else $error("Data changed just before clock release");
  c_loss: cover property ($rose(arbLost));
  c_rstart: cover property ($rose(sdaDevOe) && scl && $past(busy, 2));
  c_other_fall: cover property ($fell(scl) && !sclDevOe);
endmodule : imas_bus_props

/* File: bench/tb_i2c_multimaster_arbitration_sync.sv */
`timescale 1ns/1ps
// Two masters on one wired-AND bus: solo transfer, then a contest
module tb_i2c_multimaster_arbitration_sync;
  logic       sys_clk;    // 40 MHz system clock
  logic       rst_n;      // Synchronous reset, low
  logic       fastMode;   // Device speed select
  logic       cmdStart;   // Start or repeated start
  logic       cmdStop;    // Stop at ack end
  logic       cmdByte;    // Load next byte in ack slot
  logic [7:0] txByte;     // Device next byte
  logic       clrArbLost; // Flag clear pulse
  logic       busy;       // Device status
  logic       byteDone;
  logic [7:0] rxByte;
  logic       arbLost;
  logic       slaveMode;
  logic       othGo;      // Competitor start
  logic [7:0] othByte;    // Competitor byte
  logic       othLost;
  logic [8:0] busBits;    // Last nine bits seen on the wire
  logic       sclPrev;    // Wire clock one cycle ago
  int         runLen;     // Cycles since last wire clock edge
  int         minLow;
  int         maxLow;
  int         minHigh;
  int         mismatches;
  int         nChecks;
  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  imas_bus_if bus ();
  imas_master u_imas_master (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .bus        (bus),
    .fastMode   (fastMode),
    .cmdStart   (cmdStart),
    .cmdStop    (cmdStop),
    .cmdByte    (cmdByte),
    .txByte     (txByte),
    .clrArbLost (clrArbLost),
    .busy       (busy),
    .byteDone   (byteDone),
    .rxByte     (rxByte),
    .arbLost    (arbLost),
    .slaveMode  (slaveMode)
  );
  // Competitor keeps its own fast periods
  imas_other u_imas_other (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (bus),
    .go      (othGo),
    .txByte  (othByte),
    .lost    (othLost),
    .done    ()
  );
  imas_bus_props u_imas_bus_props (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sclDevOe  (bus.sclDevOe),
    .sdaDevOe  (bus.sdaDevOe),
    .scl       (bus.scl),
    .sda       (bus.sda),
    .fastMode  (fastMode),
    .busy      (busy),
    .byteDone  (byteDone),
    .arbLost   (arbLost),
    .slaveMode (slaveMode)
  );
  // Wire watcher: bits at clock rise, phase lengths at each edge
  always @(posedge sys_clk)
  begin
    runLen = runLen + 1;
    if (bus.scl === 1'b1 && sclPrev === 1'b0)
    begin
      busBits = {busBits[7:0], bus.sda};
      minLow = (runLen < minLow) ? runLen : minLow;
      maxLow = (runLen > maxLow) ? runLen : maxLow;
      runLen = 0;
    end
    else if (bus.scl === 1'b0 && sclPrev === 1'b1)
    begin
      minHigh = (runLen < minHigh) ? runLen : minHigh;
      runLen = 0;
    end
    sclPrev = bus.scl;
  end
  // Verdict and end of run
  task automatic give_verdict;
    if (mismatches == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Compare of a port or wire value
  task automatic check_val(input string what, input logic [8:0] exp,
                           input logic [8:0] got);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  // Compare of a measured clock phase against a window
  task automatic check_range(input string what, input int lo, input int hi,
                             input int got);
    nChecks++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range
  // Bounded wait: 0 byte end, 1 device idle
  task automatic wait_evt(input int which, input int limit);
    int   n;
    logic hit;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
      hit = (which == 0) ? byteDone : !busy;
    end
    while (hit !== 1'b1 && n < limit);
    if (hit !== 1'b1)
    begin
      mismatches++;
      $display("[FAIL] wait %0d expected event seen none", which);
      give_verdict();
    end
  endtask : wait_evt
  // One byte slot: wire bits plus ack, and the device's capture
  task automatic byte_seen(input logic [7:0] wire8, input logic [7:0] rx8);
    wait_evt(0, 6000);
    check_val("wire byte", {wire8, 1'b1}, busBits);
    check_val("rxByte", {1'b0, rx8}, {1'b0, rxByte});
  endtask : byte_seen
  // Raise start, let it be taken, drop it
  task automatic start_req;
    cmdStart = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmdStart = 1'b0;
  endtask : start_req
  // Main sequence, inputs change on falling edges
  initial
  begin
    {fastMode, cmdStart, cmdStop, cmdByte, clrArbLost, othGo} = 6'h00;
    {txByte, othByte} = 16'h0000;
    {busBits, runLen, sclPrev} = '0;
    {minLow, maxLow, minHigh, mismatches, nChecks} = '0;
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    // Solo fast transfer: ones, data, repeated start, data, stop
    fastMode = 1'b1;
    cmdByte = 1'b1;
    txByte = 8'hA5;
    minLow = 9999;
    minHigh = 9999;
    repeat (imas_pkg::BUF_FST + 4) @(negedge sys_clk);
    start_req();
    check_val("start sda", 9'h001, {8'h00, bus.sdaDevOe});
    check_val("start scl", 9'h000, {8'h00, bus.sclDevOe});
    byte_seen(8'hFF, 8'hFF);
    txByte = 8'h3C;
    cmdStart = 1'b1;
    byte_seen(8'hA5, 8'h4B);
    cmdStart = 1'b0;
    // Ones loaded at the next ack, so a fresh start sends released bits
    txByte = 8'hFF;
    // Stop level is read HD_DAT cycles into the low of the stop slot; keep it low till then
    repeat (20) @(negedge sys_clk);
    cmdStop = 1'b1;
    byte_seen(8'h3C, 8'h79);
    wait_evt(1, 2000);
    cmdStop = 1'b0;
    check_range("fast low", imas_pkg::LOW_FST, 9999, minLow);
    check_range("fast high", imas_pkg::HIGH_FST, 9999, minHigh);
    // Contest: standard device sends ones, fast competitor wins
    fastMode = 1'b0;
    cmdByte = 1'b0;
    othByte = 8'h5A;
    minHigh = 9999;
    maxLow = 0;
    repeat (imas_pkg::BUF_STD + 4) @(negedge sys_clk);
    // Both open with a start, so no restart or stop meets a data bit
    othGo = 1'b1;
    start_req();
    othGo = 1'b0;
    byte_seen(8'h5A, 8'hB5);
    check_val("arbLost", 9'h001, {8'h00, arbLost});
    check_val("slaveMode", 9'h001, {8'h00, slaveMode});
    check_val("othLost", 9'h000, {8'h00, othLost});
    check_range("sync low", imas_pkg::LOW_STD, 9999, maxLow);
    check_range("sync high", 1, imas_pkg::HIGH_FST + 8, minHigh);
    repeat (4) @(negedge sys_clk);
    check_val("scl after loss", 9'h000, {8'h00, bus.sclDevOe});
    check_val("flag sticky", 9'h001, {8'h00, arbLost});
    clrArbLost = 1'b1;
    @(negedge sys_clk);
    clrArbLost = 1'b0;
    @(negedge sys_clk);
    check_val("flag cleared", 9'h000, {8'h00, arbLost});
    give_verdict();
  end
endmodule : tb_i2c_multimaster_arbitration_sync
